// File: core_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// core sequencer model
// ====================
module core_model #(
    parameter PC_W = 12
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pc_load,
    input wire logic [PC_W-1:0] load_value,
    output logic [PC_W-1:0] pc,
    output logic boundary
);
    // one instruction a cycle, so every cycle is a boundary
    assign boundary = 1'b1;
    always @(posedge clk or posedge rst)
        if (rst)
            pc <= {{(PC_W-8){1'b0}}, 8'h10};
        else if (pc_load)
            pc <= load_value;
        else
            pc <= pc + 1'b1;
endmodule // core_model
`default_nettype wire

// File: ext_edge_detect.v
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_consts.vh"

// ==========================================================
// edge qualifier for the external request pins
// ==========================================================
module ext_edge_detect #(
    parameter N = 3
) (
    input wire clk,
    input wire rst,
    input wire [N-1:0] pins,
    input wire [2*N-1:0] sel,
    output wire [N-1:0] hit
);
    reg [N-1:0] prev_r;
    genvar g;

    function qualify;
        input [1:0] s;
        input old_v;
        input new_v;
        begin
            case (s)
                `SEL_RISE: qualify = ~old_v & new_v;
                `SEL_FALL: qualify = old_v & ~new_v;
                `SEL_BOTH: qualify = old_v ^ new_v;
                // reserved code never triggers
                default: qualify = 1'b0;
            endcase
        end
    endfunction

    always @(posedge clk or posedge rst)
    begin
        if (rst)
            prev_r <= {N{1'b0}};
        else
            prev_r <= pins;
    end

    generate
        for (g = 0; g < N; g = g + 1)
        begin : g_pin
            assign hit[g] = qualify(sel[2*g+1:2*g], prev_r[g], pins[g]);
        end
    endgenerate
endmodule // ext_edge_detect

`default_nettype wire

// File: global_and_external_irq_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_consts.vh"

// Contract
// - global enable at stack register bit 7, reset zero, blocks all vectoring
// - accepted request loads program counter with 8 and adds a stack level
// - global enable reads and writes as plain bit, 1 enables
// - one-level save buffer holds accumulator and flags for save and restore
// - restore keeps current timeout and power-down flag bits
// - three external pin sources, edge detected
// - pin flag set by edge only while that pin is enabled
// - edge waking from power-down is latched; service runs first after wake
// - pin 2 edge select at bits 5:4; 01 rise, 10 fall, 11 both
// - pin 1 edge select at bits 3:2, same encoding
// - pin 0 edge select at bits 1:0, same encoding
// - request flags stay set until software clears them
// - pin enables at bits 0..2 of enable register, reset zero
// - pin flags at bits 0..2 of request register, read/write, reset zero
module global_and_external_irq_ctrl #(
    parameter PC_W = 12,
    parameter NPINS = 3
) (
    input wire REF_CLK,
    input wire SYS_RST,
    input wire HSEL,
    input wire [31:0] HADDR,
    input wire [1:0] HTRANS,
    input wire HWRITE,
    input wire [2:0] HSIZE,
    input wire [31:0] HWDATA,
    input wire HREADY,
    output wire [31:0] HRDATA,
    output wire HREADYOUT,
    output wire HRESP,
    input wire [NPINS-1:0] EXT_IRQ_PIN,
    input wire CORE_BOUNDARY,
    input wire [PC_W-1:0] CORE_PC,
    input wire CORE_SAVE,
    input wire CORE_RESTORE,
    input wire CORE_RETURN,
    input wire [7:0] CORE_ACC,
    input wire [7:0] CORE_FLAGS,
    input wire CORE_POWER_DOWN,
    output wire PC_LOAD,
    output wire [PC_W-1:0] PC_LOAD_VALUE,
    output wire RESTORE_VALID,
    output wire [7:0] RESTORE_ACC,
    output wire [7:0] RESTORE_FLAGS,
    output wire WAKE,
    output wire IN_SERVICE,
    output wire IRQ
);
    // ==========================================================
    // state
    // ==========================================================
    reg global_irq_enable_r;
    reg [2:0] stack_depth_r;
    reg [5:0] edge_select_r;
    reg [NPINS-1:0] pin_irq_enable_r;
    reg [NPINS-1:0] pin_irq_flag_r;
    reg [4:0] other_enable_r;
    reg [4:0] other_flag_r;
    reg [7:0] save_acc_r;
    reg [7:0] save_flags_r;
    reg in_service_r;
    reg wake_latch_r;
    reg [2:0] evt_status_r;
    reg [2:0] evt_mask_r;
    reg [PC_W-1:0] pc_stack_r [0:7];
    reg pc_load_r;
    reg [PC_W-1:0] pc_load_value_r;
    reg restore_valid_r;
    reg [7:0] restore_acc_r;
    reg [7:0] restore_flags_r;
    reg wake_r;
    reg [31:0] hrdata_r;
    reg [7:0] wr_idx_r;
    reg wr_pend_r;
    reg wr_hit_r;

    wire [NPINS-1:0] edge_hit;
    wire addr_phase;
    wire rd_phase;
    wire [7:0] a_idx;
    wire a_hit;
    wire [7:0] wdata;
    wire wr_stack;
    wire wr_edge;
    wire wr_en;
    wire wr_req;
    wire wr_sacc;
    wire wr_sflags;
    wire wr_mask;
    wire rd_status;
    wire [NPINS-1:0] flag_set;
    wire [NPINS-1:0] pending;
    wire vector_go;
    wire wake_evt;
    wire return_go;
    wire [2:0] evt_set;
    wire [2:0] depth_push;
    wire [2:0] depth_pop;

    // ==========================================================
    // bus slave: zero wait states, always OKAY
    // ==========================================================
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = hrdata_r;
    assign addr_phase = HSEL & HREADY & HTRANS[1];
    assign rd_phase = addr_phase & ~HWRITE;
    assign a_idx = HADDR[9:2];
    // only aligned words inside the decoded window map to a register
    assign a_hit = (HADDR[31:10] == 22'h000000) & (HADDR[1:0] == 2'h0);
    assign wdata = HWDATA[7:0];

    function [7:0] read_mux;
        input [7:0] idx;
        begin
            case (idx)
                `IDX_STACK: read_mux = {global_irq_enable_r, 4'h0, stack_depth_r};
                `IDX_EDGE_SEL: read_mux = {2'h0, edge_select_r};
                `IDX_IRQ_EN: read_mux = {other_enable_r, pin_irq_enable_r};
                `IDX_IRQ_REQ: read_mux = {other_flag_r, pin_irq_flag_r};
                `IDX_SAVE_ACC: read_mux = save_acc_r;
                `IDX_SAVE_FLAGS: read_mux = save_flags_r;
                `IDX_EVT_STATUS: read_mux = {5'h00, evt_status_r};
                `IDX_EVT_MASK: read_mux = {5'h00, evt_mask_r};
                default: read_mux = 8'h00;
            endcase
        end
    endfunction

    always @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            hrdata_r <= 32'h00000000;
            wr_pend_r <= 1'b0;
            wr_hit_r <= 1'b0;
            wr_idx_r <= 8'h00;
        end
        else
        begin
            if (rd_phase)
                hrdata_r <= {24'h000000, (a_hit ? read_mux(a_idx) : 8'h00)};
            wr_pend_r <= addr_phase & HWRITE;
            wr_hit_r <= a_hit;
            wr_idx_r <= a_idx;
        end
    end

    assign wr_stack = wr_pend_r & wr_hit_r & (wr_idx_r == `IDX_STACK);
    assign wr_edge = wr_pend_r & wr_hit_r & (wr_idx_r == `IDX_EDGE_SEL);
    assign wr_en = wr_pend_r & wr_hit_r & (wr_idx_r == `IDX_IRQ_EN);
    assign wr_req = wr_pend_r & wr_hit_r & (wr_idx_r == `IDX_IRQ_REQ);
    assign wr_sacc = wr_pend_r & wr_hit_r & (wr_idx_r == `IDX_SAVE_ACC);
    assign wr_sflags = wr_pend_r & wr_hit_r & (wr_idx_r == `IDX_SAVE_FLAGS);
    assign wr_mask = wr_pend_r & wr_hit_r & (wr_idx_r == `IDX_EVT_MASK);
    assign rd_status = rd_phase & a_hit & (a_idx == `IDX_EVT_STATUS);

    // ==========================================================
    // external pins
    // ==========================================================
    ext_edge_detect #(
        .N(NPINS)
    ) u_edge (
        .clk(REF_CLK),
        .rst(SYS_RST),
        .pins(EXT_IRQ_PIN),
        .sel(edge_select_r),
        .hit(edge_hit)
    );

    assign flag_set = edge_hit & pin_irq_enable_r;
    assign pending = pin_irq_flag_r & pin_irq_enable_r;
    assign wake_evt = CORE_POWER_DOWN & (|flag_set);

    // ==========================================================
    // vectoring and return
    // ==========================================================
    // a latched wake edge forces entry at the first boundary after wake
    assign vector_go = CORE_BOUNDARY & ~CORE_POWER_DOWN & global_irq_enable_r
        & ~in_service_r & ((|pending) | wake_latch_r);
    assign return_go = CORE_RETURN & in_service_r;
    assign depth_push = stack_depth_r - 3'h1;
    assign depth_pop = stack_depth_r + 3'h1;

    always @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            global_irq_enable_r <= 1'b0;
            stack_depth_r <= `STACK_DEPTH_RST;
            in_service_r <= 1'b0;
            pc_load_r <= 1'b0;
            pc_load_value_r <= {PC_W{1'b0}};
        end
        else
        begin
            pc_load_r <= 1'b0;
            if (wr_stack)
                global_irq_enable_r <= HWDATA[`GIE_BIT];
            if (vector_go)
            begin
                stack_depth_r <= depth_push;
                in_service_r <= 1'b1;
                pc_load_r <= 1'b1;
                pc_load_value_r <= `VECTOR_ADDR;
            end
            else if (return_go)
            begin
                stack_depth_r <= depth_pop;
                in_service_r <= 1'b0;
                pc_load_r <= 1'b1;
                pc_load_value_r <= pc_stack_r[depth_pop];
            end
            // a depth write that meets a push or pop is dropped
            else if (wr_stack)
                stack_depth_r <= HWDATA[`DEPTH_MSB:0];
        end
    end

    // ==========================================================
    // return address stack
    // ==========================================================
    // no reset: an entry is only read back after its push; a push at
    // depth 0 writes entry 0 and wraps the depth to 7, since software may rewrite the depth
    always @(posedge REF_CLK)
    begin
        if (vector_go)
            pc_stack_r[stack_depth_r] <= CORE_PC;
    end

    // ==========================================================
    // wake latch
    // ==========================================================
    always @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            wake_latch_r <= 1'b0;
            wake_r <= 1'b0;
        end
        else
        begin
            wake_r <= wake_evt;
            if (wake_evt)
                wake_latch_r <= 1'b1;
            else if (vector_go | (CORE_BOUNDARY & ~CORE_POWER_DOWN & ~global_irq_enable_r))
                wake_latch_r <= 1'b0;
        end
    end

    // ==========================================================
    // software registers: edge select, enables, request flags
    // ==========================================================
    always @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            edge_select_r <= `EDGE_SEL_RST;
            pin_irq_enable_r <= {NPINS{1'b0}};
            pin_irq_flag_r <= {NPINS{1'b0}};
            other_enable_r <= 5'h00;
            other_flag_r <= 5'h00;
        end
        else
        begin
            if (wr_edge)
                edge_select_r <= HWDATA[5:0];
            if (wr_en)
            begin
                pin_irq_enable_r <= HWDATA[NPINS-1:0];
                other_enable_r <= HWDATA[7:3];
            end
            if (wr_req)
                other_flag_r <= HWDATA[7:3];
            // a new edge wins over a software clear in the same cycle
            pin_irq_flag_r <= (wr_req ? HWDATA[NPINS-1:0] : pin_irq_flag_r) | flag_set;
        end
    end

    // ==========================================================
    // save buffer, one level only
    // ==========================================================
    always @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            save_acc_r <= 8'h00;
            save_flags_r <= 8'h00;
            restore_valid_r <= 1'b0;
            restore_acc_r <= 8'h00;
            restore_flags_r <= 8'h00;
        end
        else
        begin
            restore_valid_r <= CORE_RESTORE;
            if (CORE_SAVE)
            begin
                save_acc_r <= CORE_ACC;
                save_flags_r <= CORE_FLAGS & ~`FLAG_KEEP_MASK;
            end
            else
            begin
                if (wr_sacc)
                    save_acc_r <= wdata;
                if (wr_sflags)
                    save_flags_r <= wdata & ~`FLAG_KEEP_MASK;
            end
            if (CORE_RESTORE)
            begin
                restore_acc_r <= save_acc_r;
                // timeout and power-down bits pass through from the live flags
                restore_flags_r <= (save_flags_r & ~`FLAG_KEEP_MASK)
                    | (CORE_FLAGS & `FLAG_KEEP_MASK);
            end
        end
    end

    // ==========================================================
    // event status, read-to-clear, masked onto IRQ
    // ==========================================================
    assign evt_set = {return_go, wake_evt, vector_go};

    always @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            evt_status_r <= 3'h0;
            evt_mask_r <= 3'h0;
        end
        else
        begin
            // set wins over the clear of a read in the same cycle
            evt_status_r <= (rd_status ? 3'h0 : evt_status_r) | evt_set;
            if (wr_mask)
                evt_mask_r <= HWDATA[2:0];
        end
    end

    // status is read-only from the bus; writes to it are dropped
    assign IRQ = |(evt_status_r & evt_mask_r);
    assign PC_LOAD = pc_load_r;
    assign PC_LOAD_VALUE = pc_load_value_r;
    assign RESTORE_VALID = restore_valid_r;
    assign RESTORE_ACC = restore_acc_r;
    assign RESTORE_FLAGS = restore_flags_r;
    assign WAKE = wake_r;
    assign IN_SERVICE = in_service_r;
endmodule // global_and_external_irq_ctrl

`default_nettype wire

// File: global_and_external_irq_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "irq_ctrl_consts.vh"
module global_and_external_irq_ctrl_tb;
    logic clk = 0;
    logic rst = 1;
    logic [1:0] htrans = 0;
    logic hwrite = 0;
    logic [31:0] haddr = 0;
    logic [31:0] hwdata = 0;
    logic [2:0] pins = 0;
    logic save = 0;
    logic restore = 0;
    logic ret = 0;
    logic pd = 0;
    logic [7:0] acc = 0;
    logic [7:0] flg = 0;
    wire [31:0] hrdata;
    wire hready;
    wire pcl, rv, wake, insvc, irq, bnd, hresp;
    wire [11:0] pclv, cpc;
    wire [7:0] racc, rflg;
    logic [11:0] pc_q;
    logic [11:0] exp_pc;
    int n_errors = 0;
    int cmp_count = 0;
    global_and_external_irq_ctrl i_dut (.REF_CLK(clk), .SYS_RST(rst), .HSEL(1'b1),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .EXT_IRQ_PIN(pins), .CORE_BOUNDARY(bnd), .CORE_PC(cpc), .CORE_SAVE(save),
        .CORE_RESTORE(restore), .CORE_RETURN(ret), .CORE_ACC(acc), .CORE_FLAGS(flg),
        .CORE_POWER_DOWN(pd), .PC_LOAD(pcl), .PC_LOAD_VALUE(pclv), .RESTORE_VALID(rv),
        .RESTORE_ACC(racc), .RESTORE_FLAGS(rflg), .WAKE(wake), .IN_SERVICE(insvc), .IRQ(irq));
    core_model i_core (.clk(clk), .rst(rst), .pc_load(pcl), .load_value(pclv), .pc(cpc),
        .boundary(bnd));
    initial forever #5 clk = ~clk;
    always @(posedge clk) pc_q <= cpc;
    // ====================
    // shared tasks
    // ====================
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task bus(input logic w, input logic [7:0] i, input logic [31:0] wd, output logic [31:0] rd);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= `IDX_TO_ADDR(i);
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask
    task wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, i, d, r);
    endtask
    task rdc(input string nm, input logic [7:0] i, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, i, 32'h0, r);
        chk(nm, e, r);
    endtask
    // bounded wait for a program counter load
    task wait_pcl;
        for (int k = 0; k < 20 && pcl !== 1'b1; k++)
            @(negedge clk);
        chk("pc_load", 1, pcl);
        // back onto the rising edge so callers drive on it
        @(posedge clk);
    endtask
    task close_out;
        $display("compares %0d errors %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ====================
    // scenarios
    // ====================
    task t_regs;
        rdc("stack", `IDX_STACK, 32'h07);
        rdc("edge", `IDX_EDGE_SEL, 32'h0);
        rdc("enable", `IDX_IRQ_EN, 32'h0);
        rdc("request", `IDX_IRQ_REQ, 32'h0);
        rdc("unmapped", 8'h10, 32'h0);
        chk("hresp", 0, hresp);
        wr(`IDX_IRQ_EN, 32'hff);
        rdc("enable rw", `IDX_IRQ_EN, 32'hff);
        wr(`IDX_IRQ_EN, 32'h0);
        wr(`IDX_IRQ_REQ, 32'h05);
        rdc("request rw", `IDX_IRQ_REQ, 32'h05);
        wr(`IDX_IRQ_REQ, 32'h0);
        wr(`IDX_STACK, 32'h87);
        rdc("gie on", `IDX_STACK, 32'h87);
        wr(`IDX_STACK, 32'h07);
        rdc("gie off", `IDX_STACK, 32'h07);
    endtask
    task t_edges;
        for (int p = 0; p < 3; p++)
            for (int s = 0; s < 4; s++)
            begin
                wr(`IDX_EDGE_SEL, s << (2 * p));
                wr(`IDX_IRQ_EN, 1 << p);
                wr(`IDX_IRQ_REQ, 0);
                pins[p] <= 1'b1;
                repeat (3) @(posedge clk);
                rdc("rise", `IDX_IRQ_REQ, (s & 1) << p);
                wr(`IDX_IRQ_REQ, 0);
                pins[p] <= 1'b0;
                repeat (3) @(posedge clk);
                rdc("fall", `IDX_IRQ_REQ, ((s >> 1) & 1) << p);
            end
        wr(`IDX_EDGE_SEL, 32'hff);
        rdc("edge rw", `IDX_EDGE_SEL, 32'h3f);
        wr(`IDX_IRQ_EN, 0);
        wr(`IDX_IRQ_REQ, 0);
        pins <= 3'h7;
        repeat (3) @(posedge clk);
        rdc("disabled", `IDX_IRQ_REQ, 0);
        pins <= 3'h0;
        repeat (3) @(posedge clk);
    endtask
    task t_vector;
        wr(`IDX_EVT_MASK, 32'h01);
        wr(`IDX_EDGE_SEL, 32'h01);
        wr(`IDX_IRQ_EN, 32'h01);
        wr(`IDX_IRQ_REQ, 0);
        wr(`IDX_STACK, 32'h87);
        pins[0] <= 1'b1;
        wait_pcl;
        exp_pc = pc_q;
        chk("vector", 12'h008, pclv);
        chk("irq", 1, irq);
        rdc("depth in", `IDX_STACK, 32'h86);
        rdc("flag kept", `IDX_IRQ_REQ, 32'h01);
        rdc("status vec", `IDX_EVT_STATUS, 32'h01);
        chk("irq clear", 0, irq);
        pins[0] <= 1'b0;
        repeat (3) @(posedge clk);
        pins[0] <= 1'b1;
        repeat (5) @(posedge clk);
        chk("still in svc", 1, insvc);
        wr(`IDX_IRQ_REQ, 0);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        wait_pcl;
        chk("return pc", exp_pc, pclv);
        chk("svc end", 0, insvc);
        chk("irq masked", 0, irq);
        rdc("depth out", `IDX_STACK, 32'h87);
        rdc("status ret", `IDX_EVT_STATUS, 32'h04);
        wr(`IDX_STACK, 32'h07);
        pins[0] <= 1'b0;
        repeat (3) @(posedge clk);
        pins[0] <= 1'b1;
        repeat (5) @(posedge clk);
        chk("gie blocks", 0, insvc);
        rdc("flag no gie", `IDX_IRQ_REQ, 32'h01);
        wr(`IDX_IRQ_REQ, 0);
        pins[0] <= 1'b0;
    endtask
    task do_sr(input logic [7:0] a, input logic [7:0] fs, input logic [7:0] fl,
        input logic [7:0] e);
        acc <= a;
        flg <= fs;
        save <= 1'b1;
        @(posedge clk);
        save <= 1'b0;
        flg <= fl;
        restore <= 1'b1;
        @(posedge clk);
        restore <= 1'b0;
        @(negedge clk);
        chk("rst valid", 1, rv);
        chk("rst acc", a, racc);
        chk("rst flags", e, rflg);
        @(posedge clk);
    endtask
    task t_wake;
        wr(`IDX_EDGE_SEL, 32'h04);
        wr(`IDX_IRQ_EN, 32'h02);
        wr(`IDX_EVT_MASK, 32'h02);
        wr(`IDX_STACK, 32'h87);
        pd <= 1'b1;
        @(posedge clk);
        pins[1] <= 1'b1;
        for (int k = 0; k < 10 && wake !== 1'b1; k++)
            @(negedge clk);
        chk("wake", 1, wake);
        chk("no vec asleep", 0, insvc);
        chk("irq wake", 1, irq);
        @(posedge clk);
        pd <= 1'b0;
        wait_pcl;
        chk("wake vector", 12'h008, pclv);
        rdc("status wake", `IDX_EVT_STATUS, 32'h03);
        wr(`IDX_IRQ_REQ, 0);
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
        wait_pcl;
        pins[1] <= 1'b0;
    endtask
    // reset again in mid-run, after every register but the request flags (already back at zero) has been moved
    task t_reset;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk("rst irq", 0, irq);
        chk("rst svc", 0, insvc);
        chk("rst hresp", 0, hresp);
        rst <= 1'b0;
        @(posedge clk);
        rdc("stack rst", `IDX_STACK, 32'h07);
        rdc("edge rst", `IDX_EDGE_SEL, 32'h0);
        rdc("enable rst", `IDX_IRQ_EN, 32'h0);
        rdc("request rst", `IDX_IRQ_REQ, 32'h0);
        rdc("mask rst", `IDX_EVT_MASK, 32'h0);
    endtask
    initial
    begin
        #200000;
        n_errors++;
        close_out;
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_edges;
        t_vector;
        do_sr(8'h5a, 8'hff, 8'h10, 8'hdf);
        do_sr(8'ha5, 8'h30, 8'h20, 8'h20);
        rdc("save acc", `IDX_SAVE_ACC, 32'ha5);
        wr(`IDX_SAVE_FLAGS, 32'hff);
        rdc("save flags", `IDX_SAVE_FLAGS, 32'hcf);
        t_wake;
        t_reset;
        close_out;
    end
endmodule // global_and_external_irq_ctrl_tb
`default_nettype wire

// File: irq_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// ====================
// port checker
// ====================
module irq_ctrl_chk #(
    parameter PC_W = 12
) (
    input wire logic REF_CLK,
    input wire logic SYS_RST,
    input wire logic CORE_SAVE,
    input wire logic CORE_RESTORE,
    input wire logic CORE_RETURN,
    input wire logic CORE_BOUNDARY,
    input wire logic CORE_POWER_DOWN,
    input wire logic [7:0] CORE_ACC,
    input wire logic [7:0] CORE_FLAGS,
    input wire logic PC_LOAD,
    input wire logic [PC_W-1:0] PC_LOAD_VALUE,
    input wire logic RESTORE_VALID,
    input wire logic [7:0] RESTORE_ACC,
    input wire logic [7:0] RESTORE_FLAGS,
    input wire logic WAKE,
    input wire logic IN_SERVICE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);
    // shadow of the one-level buffer; no reset, so restore before save is not judged
    logic [7:0] acc_r;
    logic [7:0] flg_r;
    always @(posedge REF_CLK) if (CORE_SAVE) acc_r <= CORE_ACC;
    always @(posedge REF_CLK) if (CORE_SAVE) flg_r <= CORE_FLAGS;
    sequence ret_req;
        IN_SERVICE && CORE_RETURN;
    endsequence
    sequence vec_done;
        PC_LOAD && PC_LOAD_VALUE == 8 && IN_SERVICE;
    endsequence
    vec_load_a: assert property ($rose(IN_SERVICE) |-> vec_done)
        else $error("vector entry wrong");
    vec_gate_a: assert property ($rose(IN_SERVICE) |-> $past(CORE_BOUNDARY) && !$past(CORE_POWER_DOWN))
        else $error("vector without boundary");
    svc_hold_a: assert property (IN_SERVICE && !CORE_RETURN |=> IN_SERVICE && !PC_LOAD)
        else $error("vector while in service");
    ret_pop_a: assert property (ret_req |=> PC_LOAD && !IN_SERVICE)
        else $error("return not taken");
    rst_acc_a: assert property (CORE_RESTORE |=> RESTORE_VALID && RESTORE_ACC == acc_r)
        else $error("restored acc wrong");
    rst_keep_a: assert property (CORE_RESTORE |=> RESTORE_FLAGS[5:4] == $past(CORE_FLAGS[5:4]))
        else $error("status bits not kept");
    rst_flags_a: assert property (RESTORE_VALID |-> (RESTORE_FLAGS & 8'hcf) == (flg_r & 8'hcf))
        else $error("restored flags wrong");
    wake_pd_a: assert property (WAKE |-> $past(CORE_POWER_DOWN))
        else $error("wake while awake");
endmodule // irq_ctrl_chk
bind global_and_external_irq_ctrl irq_ctrl_chk #(.PC_W(PC_W)) u_chk (.*);
`default_nettype wire

// File: irq_ctrl_consts.vh
`ifndef IRQ_CTRL_CONSTS_VH
`define IRQ_CTRL_CONSTS_VH

// ==========================================================
// register indices (printed offsets) and byte addresses
// ==========================================================
`define IDX_EDGE_SEL 8'hbf
`define IDX_STACK 8'hdf
`define IDX_IRQ_EN 8'hc9
`define IDX_IRQ_REQ 8'hc8
`define IDX_SAVE_ACC 8'he0
`define IDX_SAVE_FLAGS 8'he1
`define IDX_EVT_STATUS 8'hf0
`define IDX_EVT_MASK 8'hf1
`define IDX_TO_ADDR(i) {22'h000000, i, 2'h0}

// ==========================================================
// field positions
// ==========================================================
`define GIE_BIT 7
`define DEPTH_MSB 2
`define PIN2_SEL_MSB 5
`define PIN2_SEL_LSB 4
`define PIN1_SEL_MSB 3
`define PIN1_SEL_LSB 2
`define PIN0_SEL_MSB 1
`define PIN0_SEL_LSB 0
`define FLAG_TIMEOUT_BIT 4
`define FLAG_PDOWN_BIT 5
`define EVT_VECTOR_BIT 0
`define EVT_WAKE_BIT 1
`define EVT_RETURN_BIT 2

// ==========================================================
// reset values and encodings
// ==========================================================
`define STACK_DEPTH_RST 3'h7
`define EDGE_SEL_RST 6'h00
`define SEL_RESERVED 2'h0
`define SEL_RISE 2'h1
`define SEL_FALL 2'h2
`define SEL_BOTH 2'h3
`define VECTOR_ADDR 12'h008
`define FLAG_KEEP_MASK 8'h30

`endif
